//--- core/dmm_pkg.sv
// Package: object addresses, reset values, codes and carrier structs
package dmm_pkg;
  // ==========================================
  // Object addresses
  localparam logic [15:0] A_STOP2 = 16'h353E;
  localparam logic [15:0] A_MODE_SEL = 16'h3542;
  localparam logic [15:0] A_MODE_DSP = 16'h3544;
  localparam logic [15:0] A_POS_REF = 16'h3546;
  localparam logic [15:0] A_POS_ENC = 16'h3548;
  localparam logic [15:0] A_POS_USR = 16'h354A;
  localparam logic [15:0] A_FE_THR = 16'h354C;
  localparam logic [15:0] A_FE_TIME = 16'h354E;
  localparam logic [15:0] A_PW = 16'h3550;
  localparam logic [15:0] A_PW_TIME = 16'h3552;
  localparam logic [15:0] A_VEL = 16'h355A;
  localparam logic [15:0] A_SW = 16'h355C;
  localparam logic [15:0] A_SW_TIME = 16'h355E;
  localparam logic [15:0] A_ZS = 16'h3560;
  localparam logic [15:0] A_ZS_TIME = 16'h3562;
  localparam logic [15:0] A_TRQ_TGT = 16'h3564;
  localparam logic [15:0] A_TRQ_MAX = 16'h3566;
  localparam logic [15:0] A_TRQ_REF = 16'h356A;
  localparam logic [15:0] A_TRQ_FB = 16'h3570;
  // ==========================================
  // Reset values and limits
  localparam logic [15:0] R_STOP2 = 16'h0002;
  localparam logic [31:0] R_FE_THR = 32'h01A36AE7;
  localparam logic [31:0] R_PW = 32'h000016F0;
  localparam logic [15:0] R_SW = 16'h000A;
  localparam logic [15:0] R_ZS = 16'h000A;
  localparam logic [15:0] R_TRQ_MAX = 16'h0DAC;
  localparam logic signed [15:0] TRQ_BOUND = 16'sh0FA0;
  localparam logic signed [15:0] STOP2_MIN = -16'sh0005;
  localparam logic signed [15:0] STOP2_MAX = 16'sh0004;
  // ==========================================
  // Time base
  localparam int MS_TIME_NS = 1000000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_CYCLES = MS_TIME_NS / CLK_PERIOD_NS;
  // ==========================================
  // Operating mode and stop codes
  localparam logic [15:0] M_NONE = 16'h0000;
  localparam logic [15:0] M_PP = 16'h0001;
  localparam logic [15:0] M_PV = 16'h0003;
  localparam logic [15:0] M_PT = 16'h0004;
  localparam logic [15:0] M_HM = 16'h0006;
  localparam logic [15:0] M_IP = 16'h0007;
  typedef enum logic [2:0] {
    STOP_COAST = 3'h0,
    STOP_RAMP_PROFILE = 3'h1,
    STOP_RAMP_QUICK = 3'h2,
    STOP_EMERG_TORQUE = 3'h3,
    STOP_DYN_BRAKE = 3'h4,
    STOP_ZERO_SPEED = 3'h5
  } dmm_stop_e;
  // ==========================================
  // Carriers
  typedef struct packed {
    logic rd;
    logic wr;
    logic pdo;
    logic [15:0] addr;
    logic [31:0] wdata;
  } dmm_req_s;
  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdata;
  } dmm_rsp_s;
  typedef struct packed {
    logic signed [31:0] pos_ref;
    logic signed [31:0] pos_enc;
    logic signed [31:0] vel_user;
    logic signed [31:0] spd_target;
    logic signed [31:0] spd_actual;
    logic signed [15:0] trq_fb;
    logic signed [15:0] trq_demand;
  } dmm_fb_s;
  typedef struct packed {
    logic [15:0] mode;
    dmm_stop_e stop;
    logic brake_hold;
    logic [31:0] stop_decel;
    logic fe_fault;
    logic reached;
    logic zero_speed;
    logic signed [15:0] trq_ref;
  } dmm_ctl_s;
endpackage

//--- core/dmm_hold_timer.sv
// Window hold timer on a millisecond tick
`timescale 1ns/100ps
module dmm_hold_timer (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic tick,
  input wire logic cond,
  input wire logic [15:0] time_ms,
  output logic qual
);
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic qual_reg;
  logic qual_next;

  always_comb begin
    cnt_next = cnt_reg;
    qual_next = qual_reg;
    if (!cond) begin
      cnt_next = 16'h0000; // [RULE25]
      qual_next = 1'b0;
    end else if (cnt_reg >= time_ms) begin
      qual_next = 1'b1; // [RULE25]
    end else if (tick) begin
      cnt_next = cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= 16'h0000;
      qual_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      qual_reg <= qual_next;
    end
  end

  assign qual = qual_reg;

  hold_drop_a: assert property (@(posedge clock) disable iff (!rst_b) !cond |=> !qual) // [RULE25]
    else $error("hold qualifier survived a false condition");
  hold_zero_a: assert property (@(posedge clock) disable iff (!rst_b)
    cond && time_ms == 16'h0000 |=> qual) // [RULE25]
    else $error("zero hold time did not qualify at once");
endmodule

//--- core/dmm_gear_div.sv
// Sequential divider: encoder position times denominator over numerator
`timescale 1ns/100ps
module dmm_gear_div #(
  parameter int W = 32
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic signed [W-1:0] enc,
  input wire logic [W-1:0] num,
  input wire logic [W-1:0] den,
  output logic signed [W-1:0] quot
);
  localparam int CW = $clog2(2 * W) + 1;
  typedef enum logic [1:0] {DIV_IDLE = 2'b00, DIV_RUN = 2'b01, DIV_DONE = 2'b11} dmm_div_e;

  if (W < 8) begin : g_chk
    $error("dmm_gear_div width too small");
  end

  dmm_div_e st_reg, st_next;
  logic [2*W-1:0] prod_reg, prod_next;
  logic [W-1:0] rem_reg, rem_next;
  logic [W-1:0] dvs_reg, dvs_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic neg_reg, neg_next;
  logic signed [W-1:0] quot_reg, quot_next;
  logic [W:0] rem_sh;
  logic [W-1:0] mag;

  // Full product first so small ratios keep all precision
  always_comb begin
    st_next = st_reg;
    prod_next = prod_reg;
    rem_next = rem_reg;
    dvs_next = dvs_reg;
    cnt_next = cnt_reg;
    neg_next = neg_reg;
    quot_next = quot_reg;
    mag = enc[W-1] ? W'(-enc) : W'(enc);
    rem_sh = {rem_reg, prod_reg[2*W-1]};
    unique case (st_reg)
      DIV_IDLE: begin
        if (num != '0) begin
          prod_next = {{W{1'b0}}, mag} * {{W{1'b0}}, den};
          dvs_next = num;
          neg_next = enc[W-1];
          rem_next = '0;
          cnt_next = '0;
          st_next = DIV_RUN;
        end
      end
      DIV_RUN: begin
        prod_next = {prod_reg[2*W-2:0], 1'b0};
        if (rem_sh >= {1'b0, dvs_reg}) begin
          rem_next = W'(rem_sh - {1'b0, dvs_reg});
          prod_next[0] = 1'b1;
        end else begin
          rem_next = rem_sh[W-1:0];
        end
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == CW'(2 * W - 1)) begin
          st_next = DIV_DONE;
        end
      end
      DIV_DONE: begin
        quot_next = neg_reg ? -prod_reg[W-1:0] : prod_reg[W-1:0]; // [RULE10]
        st_next = DIV_IDLE;
      end
      default: st_next = DIV_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= DIV_IDLE;
      prod_reg <= '0;
      rem_reg <= '0;
      dvs_reg <= '0;
      cnt_reg <= '0;
      neg_reg <= 1'b0;
      quot_reg <= '0;
    end else begin
      st_reg <= st_next;
      prod_reg <= prod_next;
      rem_reg <= rem_next;
      dvs_reg <= dvs_next;
      cnt_reg <= cnt_next;
      neg_reg <= neg_next;
      quot_reg <= quot_next;
    end
  end

  assign quot = quot_reg;
endmodule

//--- core/dmm_monitor.sv
// Drive mode selection, fault stop decode and motion window monitor
// Functional notes
// (RULE1) Negative stop codes: stop then hold braking
// (RULE2) Codes 0..4: stop then leave de-energized
// (RULE3) Modes 0,1,3,4,6,7 accepted, others unsupported
// (RULE4) Mode code 0 acts as profile position
// (RULE5) Unsupported mode by service write: error
// (RULE6) Unsupported mode by process write: ignored
// (RULE7) Display shows mode in force, selector code; the code shows the selector register, 0 for mode code 0
// (RULE8) Position reference shown, signed 32 bits
// (RULE9) Encoder position feedback shown, signed 32
// (RULE10) User position equals encoder over gear
// (RULE11) Deviation beyond threshold past timeout faults
// (RULE12) Position in window for time sets reached
// (RULE13) Position reached only with servo on
// (RULE14) Speed in window for time sets reached
// (RULE15) Speed reached only while drive enabled
// (RULE16) Speed under threshold for time: zero
// (RULE17) Zero speed in velocity mode, any enable
// (RULE18) Torques signed, bounded to plus minus 4000
// (RULE19) Torque reference limited by maximum torque
// (RULE20) Torque mode commands the target torque
// (RULE21) Torque feedback shown read-only
// (RULE22) Actual velocity shown, signed 32 bits
// (RULE23) Quick-stop ramps use quick deceleration
// (RULE24) Profile ramps use profile deceleration
// (RULE25) Hold timers: ms base, restart, zero immediate
`timescale 1ns/100ps
module dmm_monitor
  import dmm_pkg::*;
#(
  parameter int TICK_CYCLES = dmm_pkg::MS_CYCLES
) (
  input wire logic clock,
  input wire logic rst_b,
  input dmm_pkg::dmm_req_s req,
  output dmm_pkg::dmm_rsp_s rsp,
  input dmm_pkg::dmm_fb_s fb,
  input wire logic [31:0] gear_num,
  input wire logic [31:0] gear_den,
  input wire logic [31:0] quick_decel,
  input wire logic [31:0] profile_decel,
  input wire logic servo_on,
  input wire logic drive_enabled,
  input wire logic fault_clear,
  output dmm_pkg::dmm_ctl_s ctl
);
  import dmm_pkg::*;

  if (TICK_CYCLES < 1) begin : g_chk
    $error("dmm_monitor tick period must be positive");
  end

  localparam int TW = $clog2(TICK_CYCLES + 1);

  // ==========================================
  // Millisecond time base
  logic [TW-1:0] tick_cnt_reg, tick_cnt_next;
  logic tick_reg, tick_next;

  always_comb begin
    tick_next = 1'b0;
    tick_cnt_next = tick_cnt_reg + 1'b1;
    if (tick_cnt_reg == TW'(TICK_CYCLES - 1)) begin
      tick_cnt_next = '0;
      tick_next = 1'b1; // [RULE25]
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      tick_reg <= tick_next;
    end
  end

  // ==========================================
  // Writable objects
  logic [15:0] mode_sel_reg, mode_sel_next;
  logic [15:0] stop2_reg, stop2_next;
  logic [31:0] fe_thr_reg, fe_thr_next;
  logic [15:0] fe_time_reg, fe_time_next;
  logic [31:0] pw_reg, pw_next;
  logic [15:0] pw_time_reg, pw_time_next;
  logic [15:0] sw_reg, sw_next;
  logic [15:0] sw_time_reg, sw_time_next;
  logic [15:0] zs_reg, zs_next;
  logic [15:0] zs_time_reg, zs_time_next;
  logic [15:0] trq_tgt_reg, trq_tgt_next;
  logic [15:0] trq_max_reg, trq_max_next;
  dmm_rsp_s rsp_reg, rsp_next;
  dmm_ctl_s ctl_reg, ctl_next;
  logic signed [31:0] pos_usr;
  logic [15:0] wd16;
  logic signed [15:0] ws16;
  logic mode_ok;
  logic bad;
  logic ro;

  always_comb begin
    wd16 = req.wdata[15:0];
    ws16 = signed'(req.wdata[15:0]);
    mode_ok = wd16 inside {M_NONE, M_PP, M_PV, M_PT, M_HM, M_IP}; // [RULE3]
    mode_sel_next = mode_sel_reg;
    stop2_next = stop2_reg;
    fe_thr_next = fe_thr_reg;
    fe_time_next = fe_time_reg;
    pw_next = pw_reg;
    pw_time_next = pw_time_reg;
    sw_next = sw_reg;
    sw_time_next = sw_time_reg;
    zs_next = zs_reg;
    zs_time_next = zs_time_reg;
    trq_tgt_next = trq_tgt_reg;
    trq_max_next = trq_max_reg;
    rsp_next = '0;
    bad = 1'b0;
    ro = 1'b0;
    unique case (req.addr)
      A_STOP2: rsp_next.rdata = {16'h0000, stop2_reg};
      A_MODE_SEL: rsp_next.rdata = {16'h0000, mode_sel_reg};
      A_MODE_DSP: begin
        rsp_next.rdata = {16'h0000, mode_sel_reg}; // [RULE7]
        ro = 1'b1;
      end
      A_POS_REF: begin
        rsp_next.rdata = fb.pos_ref; // [RULE8]
        ro = 1'b1;
      end
      A_POS_ENC: begin
        rsp_next.rdata = fb.pos_enc; // [RULE9]
        ro = 1'b1;
      end
      A_POS_USR: begin
        rsp_next.rdata = pos_usr; // [RULE10]
        ro = 1'b1;
      end
      A_FE_THR: rsp_next.rdata = fe_thr_reg;
      A_FE_TIME: rsp_next.rdata = {16'h0000, fe_time_reg};
      A_PW: rsp_next.rdata = pw_reg;
      A_PW_TIME: rsp_next.rdata = {16'h0000, pw_time_reg};
      A_VEL: begin
        rsp_next.rdata = fb.vel_user; // [RULE22]
        ro = 1'b1;
      end
      A_SW: rsp_next.rdata = {16'h0000, sw_reg};
      A_SW_TIME: rsp_next.rdata = {16'h0000, sw_time_reg};
      A_ZS: rsp_next.rdata = {16'h0000, zs_reg};
      A_ZS_TIME: rsp_next.rdata = {16'h0000, zs_time_reg};
      A_TRQ_TGT: rsp_next.rdata = {16'h0000, trq_tgt_reg};
      A_TRQ_MAX: rsp_next.rdata = {16'h0000, trq_max_reg};
      A_TRQ_REF: begin
        rsp_next.rdata = {16'h0000, ctl_reg.trq_ref};
        ro = 1'b1;
      end
      A_TRQ_FB: begin
        rsp_next.rdata = {16'h0000, fb.trq_fb}; // [RULE21]
        ro = 1'b1;
      end
      default: bad = 1'b1;
    endcase
    // Out-of-range values never land; only service writes report it
    if (req.wr && !bad && !ro) begin
      unique case (req.addr)
        A_STOP2: begin
          if (ws16 >= STOP2_MIN && ws16 <= STOP2_MAX) begin
            stop2_next = wd16;
          end else begin
            bad = 1'b1;
          end
        end
        A_MODE_SEL: begin
          if (mode_ok) begin
            mode_sel_next = wd16;
          end else begin
            bad = 1'b1; // [RULE5] [RULE6]
          end
        end
        A_FE_THR: fe_thr_next = req.wdata;
        A_FE_TIME: fe_time_next = wd16;
        A_PW: pw_next = req.wdata;
        A_PW_TIME: pw_time_next = wd16;
        A_SW: sw_next = wd16;
        A_SW_TIME: sw_time_next = wd16;
        A_ZS: zs_next = wd16;
        A_ZS_TIME: zs_time_next = wd16;
        A_TRQ_TGT: begin
          if (ws16 >= -TRQ_BOUND && ws16 <= TRQ_BOUND) begin
            trq_tgt_next = wd16; // [RULE18]
          end else begin
            bad = 1'b1;
          end
        end
        A_TRQ_MAX: begin
          if (wd16 <= 16'(TRQ_BOUND)) begin
            trq_max_next = wd16; // [RULE18]
          end else begin
            bad = 1'b1;
          end
        end
        default: bad = 1'b1;
      endcase
    end
    rsp_next.ack = req.rd || req.wr;
    rsp_next.err = (req.rd || (req.wr && !req.pdo)) && (bad || (req.wr && ro)); // [RULE5] [RULE6]
    if (req.wr || !req.rd) begin
      rsp_next.rdata = '0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mode_sel_reg <= M_NONE;
      stop2_reg <= R_STOP2;
      fe_thr_reg <= R_FE_THR;
      fe_time_reg <= 16'h0000;
      pw_reg <= R_PW;
      pw_time_reg <= 16'h0000;
      sw_reg <= R_SW;
      sw_time_reg <= 16'h0000;
      zs_reg <= R_ZS;
      zs_time_reg <= 16'h0000;
      trq_tgt_reg <= 16'h0000;
      trq_max_reg <= R_TRQ_MAX;
      rsp_reg <= '0;
    end else begin
      mode_sel_reg <= mode_sel_next;
      stop2_reg <= stop2_next;
      fe_thr_reg <= fe_thr_next;
      fe_time_reg <= fe_time_next;
      pw_reg <= pw_next;
      pw_time_reg <= pw_time_next;
      sw_reg <= sw_next;
      sw_time_reg <= sw_time_next;
      zs_reg <= zs_next;
      zs_time_reg <= zs_time_next;
      trq_tgt_reg <= trq_tgt_next;
      trq_max_reg <= trq_max_next;
      rsp_reg <= rsp_next;
    end
  end

  // ==========================================
  // Position feedback in user units
  dmm_gear_div #(.W(32)) u_div (
    .clock(clock),
    .rst_b(rst_b),
    .enc(fb.pos_enc),
    .num(gear_num),
    .den(gear_den),
    .quot(pos_usr)
  );

  // ==========================================
  // Window compares and hold timers
  logic signed [32:0] pdiff, sdiff;
  logic [32:0] pabs, sabs, zabs;
  logic fe_cond, pw_cond, sw_cond, zs_cond;
  logic fe_q, pw_q, sw_q, zs_q;

  // Position compares use the user-unit feedback, as reference units demand
  always_comb begin
    pdiff = 33'(fb.pos_ref) - 33'(pos_usr);
    sdiff = 33'(fb.spd_target) - 33'(fb.spd_actual);
    pabs = pdiff[32] ? 33'(-pdiff) : 33'(pdiff);
    sabs = sdiff[32] ? 33'(-sdiff) : 33'(sdiff);
    zabs = fb.spd_actual[31] ? 33'(-33'(fb.spd_actual)) : 33'(fb.spd_actual);
    fe_cond = pabs > {1'b0, fe_thr_reg}; // [RULE11]
    pw_cond = pabs <= {1'b0, pw_reg}; // [RULE12]
    sw_cond = sabs <= {17'h00000, sw_reg}; // [RULE14]
    zs_cond = zabs <= {17'h00000, zs_reg}; // [RULE16]
  end

  dmm_hold_timer u_fe (.clock(clock), .rst_b(rst_b), .tick(tick_reg), .cond(fe_cond),
    .time_ms(fe_time_reg), .qual(fe_q));
  dmm_hold_timer u_pw (.clock(clock), .rst_b(rst_b), .tick(tick_reg), .cond(pw_cond),
    .time_ms(pw_time_reg), .qual(pw_q));
  dmm_hold_timer u_sw (.clock(clock), .rst_b(rst_b), .tick(tick_reg), .cond(sw_cond),
    .time_ms(sw_time_reg), .qual(sw_q));
  dmm_hold_timer u_zs (.clock(clock), .rst_b(rst_b), .tick(tick_reg), .cond(zs_cond),
    .time_ms(zs_time_reg), .qual(zs_q));

  // ==========================================
  // Mode, stop decode, torque and status
  logic [15:0] mode_eff;
  logic signed [15:0] tcmd, tmax;

  always_comb begin
    ctl_next = ctl_reg;
    mode_eff = (mode_sel_reg == M_NONE) ? M_PP : mode_sel_reg; // [RULE4]
    ctl_next.mode = mode_eff;
    unique case (signed'(stop2_reg))
      -16'sd5: ctl_next.stop = STOP_ZERO_SPEED; // [RULE1]
      -16'sd4: ctl_next.stop = STOP_EMERG_TORQUE;
      -16'sd3: ctl_next.stop = STOP_RAMP_QUICK;
      -16'sd2: ctl_next.stop = STOP_RAMP_PROFILE;
      -16'sd1: ctl_next.stop = STOP_DYN_BRAKE;
      16'sd1: ctl_next.stop = STOP_RAMP_PROFILE; // [RULE2]
      16'sd2: ctl_next.stop = STOP_RAMP_QUICK;
      16'sd3: ctl_next.stop = STOP_EMERG_TORQUE;
      16'sd4: ctl_next.stop = STOP_DYN_BRAKE;
      default: ctl_next.stop = STOP_COAST;
    endcase
    ctl_next.brake_hold = stop2_reg[15]; // [RULE1] [RULE2]
    unique case (ctl_next.stop)
      STOP_RAMP_QUICK: ctl_next.stop_decel = quick_decel; // [RULE23]
      STOP_RAMP_PROFILE: ctl_next.stop_decel = profile_decel; // [RULE24]
      default: ctl_next.stop_decel = 32'h00000000;
    endcase
    // Set wins over clear
    ctl_next.fe_fault = fe_q || (ctl_reg.fe_fault && !fault_clear); // [RULE11]
    ctl_next.reached = (mode_eff == M_PP && servo_on && pw_q) // [RULE12] [RULE13]
      || (mode_eff == M_PV && drive_enabled && sw_q); // [RULE14] [RULE15]
    ctl_next.zero_speed = (mode_eff == M_PV) && zs_q; // [RULE16] [RULE17]
    tcmd = (mode_eff == M_PT) ? signed'(trq_tgt_reg) : fb.trq_demand; // [RULE20]
    tmax = signed'(trq_max_reg);
    if (tcmd > tmax) begin
      ctl_next.trq_ref = tmax; // [RULE19]
    end else if (tcmd < -tmax) begin
      ctl_next.trq_ref = -tmax;
    end else begin
      ctl_next.trq_ref = tcmd;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctl_reg <= '{mode: M_PP, stop: STOP_RAMP_QUICK, default: '0};
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  assign ctl = ctl_reg;
  assign rsp = rsp_reg;

  // ==========================================
  // Checks
  mode_sdo_reject_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE5]
    req.wr && !req.pdo && req.addr == A_MODE_SEL && !mode_ok |=> rsp.err && rsp.ack)
    else $error("unsupported mode by service write gave no error");
  mode_pdo_keep_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE6]
    req.wr && req.pdo && req.addr == A_MODE_SEL && !mode_ok |=> !rsp.err && $stable(mode_sel_reg))
    else $error("unsupported mode by process write was taken");
  mode_zero_pp_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE4]
    mode_sel_reg == M_NONE ##1 mode_sel_reg == M_NONE |-> ctl.mode == M_PP)
    else $error("mode code zero not run as position mode");
  stop_brake_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE1]
    signed'(stop2_reg) == -16'sd5 |=> ctl.stop == STOP_ZERO_SPEED && ctl.brake_hold)
    else $error("zero-speed stop code decoded wrongly");
  stop_coast_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE2]
    stop2_reg == 16'h0000 |=> ctl.stop == STOP_COAST && !ctl.brake_hold)
    else $error("coast stop code decoded wrongly");
  torque_limit_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE19]
    ##1 $past(trq_max_reg) == trq_max_reg |-> ctl.trq_ref <= signed'(trq_max_reg)
    && ctl.trq_ref >= -signed'(trq_max_reg))
    else $error("torque reference beyond maximum torque");
  fe_raise_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE11]
    $rose(ctl.fe_fault) |-> $past(fe_q) && $past(fe_cond, 2))
    else $error("deviation fault without qualified deviation");
  reach_gate_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE13]
    ctl.reached && ctl.mode == M_PP |-> $past(servo_on) && $past(pw_q))
    else $error("position reached without servo on");
endmodule

//--- testbench/dmm_host.sv
// Host controller model issuing object reads and writes
`timescale 1ns/100ps
module dmm_host
  import dmm_pkg::*;
(
  input wire logic clock,
  output dmm_pkg::dmm_req_s req,
  input dmm_pkg::dmm_rsp_s rsp
);
  // ==========================================
  // One access per call, strobe for one edge
  initial req = '0;
  task automatic access(input logic w, input logic p, input logic [15:0] a, input logic [31:0] d,
                        output logic e, output logic [31:0] q, output logic ok);
    int n;
    req = '{rd: !w, wr: w, pdo: p, addr: a, wdata: d};
    @(posedge clock);
    #1;
    // Strobes cleared, other fields inverted so a stale request never looks valid
    req = '{rd: 1'b0, wr: 1'b0, pdo: !p, addr: ~a, wdata: ~d};
    n = 0;
    while (rsp.ack !== 1'b1 && n < 4) begin
      @(posedge clock);
      #1;
      n++;
    end
    ok = rsp.ack === 1'b1;
    e = rsp.err;
    q = rsp.rdata;
  endtask
endmodule

//--- testbench/testbench.sv
// Self-checking bench for the drive mode and motion monitor
`timescale 1ns/100ps
module testbench;
  import dmm_pkg::*;
  // ==========================================
  // Stimulus and design
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  dmm_req_s req;
  dmm_rsp_s rsp;
  dmm_fb_s fb = '0;
  dmm_ctl_s ctl;
  logic [31:0] gear_num = 32'h1;
  logic [31:0] gear_den = 32'h1;
  logic [31:0] quick_decel = 32'h7FFFFFFF;
  logic [31:0] profile_decel = 32'h53555555;
  logic servo_on = 1'b0;
  logic drive_enabled = 1'b0;
  logic fault_clear = 1'b0;
  int mismatches = 0;
  int total_checks = 0;
  always #10 clock = ~clock;
  dmm_monitor #(.TICK_CYCLES(4)) u_dut (.clock(clock), .rst_b(rst_b), .req(req), .rsp(rsp), .fb(fb),
    .gear_num(gear_num), .gear_den(gear_den), .quick_decel(quick_decel), .profile_decel(profile_decel),
    .servo_on(servo_on), .drive_enabled(drive_enabled), .fault_clear(fault_clear), .ctl(ctl));
  dmm_host u_host (.clock(clock), .req(req), .rsp(rsp));
  // ==========================================
  // Shared tasks
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic bus(input logic w, input logic p, input logic [15:0] a, input logic [31:0] d,
                     input logic e, output logic [31:0] q);
    logic ge;
    logic ok;
    u_host.access(w, p, a, d, ge, q, ok);
    if (!ok) begin
      mismatches++;
      final_report();
    end
    chk(32'(ge), 32'(e));
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic p = 1'b0, input logic e = 1'b0);
    logic [31:0] q;
    bus(1'b1, p, a, d, e, q);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] x, input logic e = 1'b0);
    logic [31:0] q;
    bus(1'b0, 1'b0, a, 32'h0, e, q);
    if (!e) chk(q, x);
  endtask
  // Flag 0 zero speed, 1 reached, 2 deviation fault
  task automatic wait_flag(input int k, input logic v, input int lim);
    logic f;
    for (int n = 0; n <= lim; n++) begin
      f = k == 0 ? ctl.zero_speed : k == 1 ? ctl.reached : ctl.fe_fault;
      if (f === v) break;
      cyc(1);
    end
    chk(32'(f), 32'(v));
    if (f !== v) final_report();
  endtask
  // ==========================================
  // Scenarios
  task automatic s_reset();
    chk(32'(ctl.mode), 32'(M_PP));
    rd(A_MODE_SEL, 32'h0);
    rd(A_STOP2, 32'h2);
    rd(A_FE_THR, 32'h01A36AE7);
    rd(A_PW, 32'h16F0);
    rd(A_ZS, 32'hA);
    rd(A_TRQ_MAX, 32'hDAC);
    rd(16'h3600, 32'h0, 1'b1);
    wr(A_POS_REF, 32'h1, 1'b0, 1'b1);
  endtask
  task automatic s_mode();
    logic [15:0] m[6] = '{16'h0, 16'h1, 16'h3, 16'h4, 16'h6, 16'h7};
    foreach (m[i]) begin
      wr(A_MODE_SEL, 32'(m[i]));
      cyc(2);
      chk(32'(ctl.mode), m[i] == 16'h0 ? 32'h1 : 32'(m[i]));
      rd(A_MODE_DSP, 32'(m[i]));
    end
    wr(A_MODE_SEL, 32'h2, 1'b0, 1'b1);
    wr(A_MODE_SEL, 32'h5, 1'b1, 1'b0);
    cyc(2);
    chk(32'(ctl.mode), 32'h7);
  endtask
  task automatic s_stop();
    dmm_stop_e es;
    for (int c = -5; c <= 4; c++) begin
      wr(A_STOP2, 32'(16'(c)));
      case (c)
        -5: es = STOP_ZERO_SPEED;
        -4, 3: es = STOP_EMERG_TORQUE;
        -3, 2: es = STOP_RAMP_QUICK;
        -2, 1: es = STOP_RAMP_PROFILE;
        -1, 4: es = STOP_DYN_BRAKE;
        default: es = STOP_COAST;
      endcase
      cyc(2);
      chk(32'(ctl.stop), 32'(es));
      chk(32'(ctl.brake_hold), 32'(c < 0));
      chk(ctl.stop_decel, es == STOP_RAMP_QUICK ? quick_decel :
          es == STOP_RAMP_PROFILE ? profile_decel : 32'h0);
    end
    wr(A_STOP2, 32'h5, 1'b0, 1'b1);
  endtask
  task automatic s_torque();
    fb.trq_fb = -16'sh007B;
    wr(A_MODE_SEL, 32'h4);
    wr(A_TRQ_MAX, 32'h7D0);
    wr(A_TRQ_TGT, 32'hF448);
    cyc(3);
    chk(32'(ctl.trq_ref), 32'hFFFFF830);
    wr(A_TRQ_TGT, 32'h5DC);
    cyc(3);
    chk(32'(ctl.trq_ref), 32'h5DC);
    wr(A_TRQ_TGT, 32'hFA1, 1'b0, 1'b1);
    wr(A_TRQ_MAX, 32'hFA1, 1'b0, 1'b1);
    rd(A_TRQ_FB, 32'hFF85);
  endtask
  task automatic s_speed();
    fb.spd_actual = 32'sh32;
    fb.vel_user = -32'sh2;
    wr(A_MODE_SEL, 32'h3);
    wr(A_ZS_TIME, 32'h3);
    rd(A_VEL, 32'hFFFFFFFE);
    fb.spd_actual = 32'sh5;
    cyc(6);
    chk(32'(ctl.zero_speed), 32'h0);
    wait_flag(0, 1'b1, 20);
    fb.spd_actual = 32'shB;
    wait_flag(0, 1'b0, 4);
    fb.spd_target = 32'sh64;
    fb.spd_actual = 32'sh5F;
    drive_enabled = 1'b1;
    wait_flag(1, 1'b1, 4);
    drive_enabled = 1'b0;
    wait_flag(1, 1'b0, 4);
  endtask
  task automatic s_pos();
    gear_num = 32'h2;
    fb.pos_enc = 32'sh190;
    fb.pos_ref = 32'shC8;
    wr(A_MODE_SEL, 32'h1);
    wr(A_FE_THR, 32'h1F4);
    wr(A_FE_TIME, 32'h2);
    cyc(150);
    rd(A_POS_ENC, 32'h190);
    rd(A_POS_USR, 32'hC8);
    servo_on = 1'b1;
    wait_flag(1, 1'b1, 6);
    fb.pos_ref = 32'sh20C8;
    cyc(2);
    chk(32'(ctl.fe_fault), 32'h0);
    wait_flag(1, 1'b0, 4);
    wait_flag(2, 1'b1, 30);
    rd(A_POS_REF, 32'h20C8);
    fb.pos_ref = 32'shC8;
    fault_clear = 1'b1;
    cyc(3);
    fault_clear = 1'b0;
    wait_flag(2, 1'b0, 4);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    cyc(16);
    rst_b = 1'b1;
    cyc(1);
    s_reset();
    s_mode();
    s_stop();
    s_torque();
    s_speed();
    s_pos();
    final_report();
  end
endmodule
